// ==== dts_pkg.sv ====
// constants, types and the state record of the debug trigger and run status block
// How it works
// - trigger setup writable only while disarmed
// - exec-qualify bit waits for opcode execution
// - begin/end bit picks storage window
// - event-only modes always run as begin
// - modes 0-2: A, A or B, A then B
// - modes 3-4 store on B events
// - modes 5-6 address A with B data
// - modes 7-8 inside or outside range
// - modes 9 to 15 never trigger
// - A flag cleared at arm, set on match
// - B flag cleared at arm, set on match
// - armed status mirrors capture control
// - run ends on full or trigger
// - host aborts by clearing arm or enable
// - valid count cleared at arm, up to eight
// - count holds while FIFO is read
// - run status register is read-only
// - arm write sets control and armed flag
// - enable refused while secure
package dts_pkg;
   // ****************************************************
   // register map, byte addresses on the apb bus
   // ****************************************************
   localparam logic [7:0] DTS_OFF_CTRL   = 8'h00; // debug_control_reg
   localparam logic [7:0] DTS_OFF_TRIG   = 8'h04; // trigger_setup_reg
   localparam logic [7:0] DTS_OFF_STATUS = 8'h08; // run_status_reg
   // ****************************************************
   // field positions
   // ****************************************************
   localparam int DTS_EN_BIT    = 7; // debug_unit_enable
   localparam int DTS_ARM_BIT   = 6; // capture-active control
   localparam int DTS_QUAL_BIT  = 7; // exec_qualify_sel
   localparam int DTS_BEGIN_BIT = 6; // begin/end select
   localparam int DTS_AF_BIT    = 7; // match_a_flag
   localparam int DTS_BF_BIT    = 6; // match_b_flag
   localparam int DTS_CAPTURE_ACTIVE_FLAG_BIT  = 5; // capture_active_flag
   localparam logic [7:0] DTS_TRIG_WMASK = 8'hcf; // bits 5:4 fixed zero
   localparam logic [3:0] DTS_FIFO_DEPTH = 4'h8;  // words in trace fifo
   // ****************************************************
   // trigger modes
   // ****************************************************
   typedef enum logic [3:0] {
      DTS_M_A       = 4'h0,
      DTS_M_A_OR_B  = 4'h1,
      DTS_M_A_THENB = 4'h2,
      DTS_M_EV_B    = 4'h3,
      DTS_M_A_EV_B  = 4'h4,
      DTS_M_A_AND_D = 4'h5,
      DTS_M_A_NOT_D = 4'h6,
      DTS_M_INSIDE  = 4'h7,
      DTS_M_OUTSIDE = 4'h8
   } dts_mode_t;
   // run phase, one-hot
   typedef enum logic [2:0] {
      DTS_ST_IDLE  = 3'b001,
      DTS_ST_ARMED = 3'b010,
      DTS_ST_STORE = 3'b100
   } dts_phase_t;
   // apb request from the master
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } dts_apb_req_t;
   // per-cycle events from comparators and opcode tracking
   typedef struct packed {
      logic access;  // bus access this cycle
      logic a;       // address equals comparator a
      logic b;       // address equals comparator b
      logic b_data;  // data equals comparator b
      logic lt_a;    // address below a
      logic gt_b;    // address above b
      logic cof;     // change-of-flow word ready to store
      logic exec;    // tagged opcode executed
      logic flush;   // tagged opcode discarded
   } dts_hits_t;
   // whole state of the block
   typedef struct packed {
      logic        en;
      logic        arm;
      logic [7:0]  trig;
      logic        flag_a;
      logic        flag_b;
      logic [3:0]  cnt;
      logic        a_seen;
      logic [2:0]  pend;    // tagged a, b, mode hit
      dts_phase_t  phase;
      logic        store;
      logic        trig_ev;
      logic [31:0] prdata;
   } dts_state_t;
endpackage

// ==== dts_debug_trigger.sv ====
// trigger setup, run control and run status of the debug trace unit
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module dts_debug_trigger
(
   input  wire logic               pclk,        // cpu bus clock
   input  wire logic               presetn,     // async reset
   input  wire dts_pkg::dts_apb_req_t apb_req,  // apb request
   output logic                    pready,      // always ready
   output logic                    pslverr,     // unmapped address
   output logic [31:0]             prdata,      // read data
   input  wire dts_pkg::dts_hits_t hits,        // comparator events
   input  wire logic               secure_mode, // mcu secured
   output logic                    fifo_store,  // store one word
   output logic                    trigger_event, // trigger pulse
   output logic                    run_armed    // run in progress
);
   import dts_pkg::*;

   // ****************************************************
   // bus decode
   // ****************************************************
   dts_state_t q;        // registered state
   dts_state_t d;        // next state
   logic       wr;       // write at access edge
   logic       setup;    // setup cycle of a transfer
   logic       hit_ctrl; // address decodes
   logic       hit_trig;
   logic       hit_stat;
   logic       mapped;
   logic [7:0] status;   // run_status_reg image
   logic [2:0] raw;      // unqualified a, b, mode hit
   logic [2:0] qual;     // qualified a, b, mode hit
   logic       fire;     // trigger this cycle
   logic       bstore;   // event-only store this cycle
   logic       evonly;   // event-only mode selected
   logic       begin_tr; // run behaves as begin trace
   logic       full;     // fifo reaches depth
   dts_mode_t  mode;

   // decoding by address chain
   always_comb
   begin
      hit_ctrl = 1'b0;
      hit_trig = 1'b0;
      hit_stat = 1'b0;
      if (apb_req.paddr == DTS_OFF_CTRL)
      begin
         hit_ctrl = 1'b1;
      end
      else if (apb_req.paddr == DTS_OFF_TRIG)
      begin
         hit_trig = 1'b1;
      end
      else if (apb_req.paddr == DTS_OFF_STATUS)
      begin
         hit_stat = 1'b1;
      end
   end

   assign mapped  = hit_ctrl | hit_trig | hit_stat;
   assign wr      = apb_req.psel & apb_req.penable & apb_req.pwrite;
   assign setup   = apb_req.psel & ~apb_req.penable;
   // zero wait states: read data is loaded in the setup cycle
   assign pready  = 1'b1;
   assign pslverr = apb_req.psel & apb_req.penable & ~mapped;
   assign prdata  = q.prdata;
   assign fifo_store    = q.store;
   assign trigger_event = q.trig_ev;
   assign run_armed     = q.arm;

   // status image; armed bit is the control bit gated by enable
   assign status = {q.flag_a, q.flag_b, q.arm & q.en, 1'b0, q.cnt};

   // ****************************************************
   // trigger evaluation
   // ****************************************************
   assign mode   = dts_mode_t'(q.trig[3:0]);
   assign evonly = (mode == DTS_M_EV_B) | (mode == DTS_M_A_EV_B);
   // event-only modes ignore the begin/end select
   assign begin_tr = q.trig[DTS_BEGIN_BIT] | evonly;

   // raw hits on one access
   always_comb
   begin
      raw = 3'b000;
      if (hits.access)
      begin
         raw[2] = hits.a;
         raw[1] = hits.b;
         case (mode)
            DTS_M_A_AND_D : raw[0] = hits.a & hits.b_data;
            DTS_M_A_NOT_D : raw[0] = hits.a & ~hits.b_data;
            DTS_M_INSIDE  : raw[0] = ~hits.lt_a & ~hits.gt_b;
            DTS_M_OUTSIDE : raw[0] = hits.lt_a | hits.gt_b;
            default       : raw[0] = 1'b0;
         endcase
      end
   end

   // tagged hits wait for the opcode to execute; a flush drops them
   always_comb
   begin
      if (q.trig[DTS_QUAL_BIT])
      begin
         qual = hits.exec ? q.pend : 3'b000;
      end
      else
      begin
         qual = raw;
      end
   end

   // trigger per mode; unused codes never fire
   always_comb
   begin
      fire   = 1'b0;
      bstore = 1'b0;
      case (mode)
         DTS_M_A       : fire = qual[2];
         DTS_M_A_OR_B  : fire = qual[2] | qual[1];
         DTS_M_A_THENB : fire = qual[1] & q.a_seen;
         DTS_M_EV_B    : bstore = qual[1];
         DTS_M_A_EV_B  : bstore = qual[1] & q.a_seen;
         DTS_M_A_AND_D,
         DTS_M_A_NOT_D,
         DTS_M_INSIDE,
         DTS_M_OUTSIDE : fire = qual[0];
         default       : fire = 1'b0;
      endcase
   end

   // ****************************************************
   // next state
   // ****************************************************
   always_comb
   begin
      d         = q;
      d.store   = 1'b0;
      d.trig_ev = 1'b0;
      full      = 1'b0;
      if (q.trig[DTS_QUAL_BIT])
      begin
         // collect tagged hits until executed or flushed
         // a hit in the exec cycle itself waits for the next exec
         if (hits.exec | hits.flush)
         begin
            d.pend = raw;
         end
         else
         begin
            d.pend = q.pend | raw;
         end
      end
      else
      begin
         d.pend = 3'b000;
      end
      // read data loaded in setup; status has no side effect
      if (setup & ~apb_req.pwrite)
      begin
         if (hit_ctrl)
         begin
            d.prdata = {24'h000000, q.en, q.arm, 6'h00};
         end
         else if (hit_trig)
         begin
            d.prdata = {24'h000000, q.trig};
         end
         else if (hit_stat)
         begin
            d.prdata = {24'h000000, status};
         end
         else
         begin
            d.prdata = 32'h00000000;
         end
      end
      // run progress while armed
      if (q.phase != DTS_ST_IDLE)
      begin
         // flags only move inside a run
         if (qual[2])
         begin
            d.flag_a = 1'b1;
            d.a_seen = 1'b1;
         end
         if (qual[1])
         begin
            d.flag_b = 1'b1;
         end
         d.trig_ev = fire;
         case (q.phase)
            DTS_ST_ARMED :
            begin
               if (evonly)
               begin
                  // each B event stores one word, in mode 4 only after A
                  d.store = bstore;
                  if (bstore)
                  begin
                     d.cnt = q.cnt + 4'h1;
                     full  = (q.cnt + 4'h1) == DTS_FIFO_DEPTH;
                  end
               end
               else if (begin_tr)
               begin
                  if (fire)
                  begin
                     d.phase = DTS_ST_STORE;
                  end
               end
               else
               begin
                  // end trace: circular fill, count saturates at depth
                  d.store = hits.cof;
                  if (hits.cof && q.cnt != DTS_FIFO_DEPTH)
                  begin
                     d.cnt = q.cnt + 4'h1;
                  end
                  if (fire)
                  begin
                     d.phase = DTS_ST_IDLE;
                     d.arm   = 1'b0;
                  end
               end
            end
            DTS_ST_STORE :
            begin
               d.store = hits.cof;
               if (hits.cof)
               begin
                  d.cnt = q.cnt + 4'h1;
                  full  = (q.cnt + 4'h1) == DTS_FIFO_DEPTH;
               end
            end
            default : d.phase = DTS_ST_IDLE;
         endcase
         // a full fifo ends the run whatever the phase chose above
         if (full)
         begin
            d.phase = DTS_ST_IDLE;
            d.arm   = 1'b0;
         end
      end
      // register writes, after run progress so the host wins
      if (wr & hit_ctrl)
      begin
         // a secured part keeps the unit disabled
         d.en = apb_req.pwdata[DTS_EN_BIT] & (q.en | ~secure_mode);
         if (apb_req.pwdata[DTS_ARM_BIT] & d.en)
         begin
            if (q.phase == DTS_ST_IDLE)
            begin
               // new run: clear flags and count
               d.arm    = 1'b1;
               d.phase  = DTS_ST_ARMED;
               d.flag_a = 1'b0;
               d.flag_b = 1'b0;
               d.cnt    = 4'h0;
               d.a_seen = 1'b0;
               d.pend   = 3'b000;
               d.store  = 1'b0;
            end
         end
         else
         begin
            // abort; count keeps what was stored
            d.arm   = 1'b0;
            d.phase = DTS_ST_IDLE;
         end
      end
      if (wr & hit_trig & ~q.arm)
      begin
         d.trig = apb_req.pwdata[7:0] & DTS_TRIG_WMASK;
      end
      // writes to run_status_reg fall through untouched
   end

   // state register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         q        <= '0;
         // all zero is no legal one-hot code, so idle is set apart
         q.phase  <= DTS_ST_IDLE;
      end
      else
      begin
         q <= d;
      end
   end

   // ****************************************************
   // checks
   // ****************************************************
   // one clock domain, so one default clock and reset serve every check
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_SETUP_LOCK: assert property (wr & hit_trig & q.arm |=> $stable(q.trig))
      else $error("trigger setup changed while armed");
   AST_SETUP_ZERO: assert property (q.trig[5:4] == 2'b00)
      else $error("fixed bits of trigger setup not zero");
   AST_CAPTURE_ACTIVE_FLAG_IMAGE: assert property (status[DTS_CAPTURE_ACTIVE_FLAG_BIT] == (q.arm & q.en))
      else $error("armed status not mirroring control");
   AST_ARM_START: assert property (wr & hit_ctrl & q.en & ~secure_mode & ~q.arm &
      apb_req.pwdata[DTS_EN_BIT] & apb_req.pwdata[DTS_ARM_BIT] |=>
      q.arm & ~q.flag_a & ~q.flag_b & (q.cnt == 4'h0))
      else $error("run start did not clear flags and count");
   AST_END_TRIG: assert property (q.phase == DTS_ST_ARMED & ~begin_tr & fire & ~wr
      |=> ~q.arm ##1 ~q.arm)
      else $error("end trace did not stop on trigger");
   AST_FULL_END: assert property (q.phase == DTS_ST_STORE & hits.cof &
      q.cnt == 4'h7 & ~wr |=> ~q.arm & q.cnt == 4'h8)
      else $error("begin trace did not stop at eight words");
   AST_ABORT: assert property (wr & hit_ctrl & ~apb_req.pwdata[DTS_ARM_BIT]
      |=> ~q.arm & q.phase == DTS_ST_IDLE)
      else $error("abort write left run armed");
   AST_SECURE: assert property (secure_mode & ~q.en |=> ~q.en)
      else $error("enable set while secure");
   AST_NO_TRIG: assert property (q.trig[3:0] > 4'h8 |-> ~fire & ~bstore)
      else $error("reserved mode produced a trigger");
   AST_FLAG_HOLD: assert property (q.phase == DTS_ST_IDLE & ~wr
      |=> $stable(q.flag_a) & $stable(q.flag_b))
      else $error("match flag moved outside a run");
   // status writes, tagged waits, count range and the trigger output
   AST_RO_STATUS: assert property (wr & hit_stat & q.phase == DTS_ST_IDLE |=>
      $stable(q.flag_a) & $stable(q.flag_b) & $stable(q.cnt))
      else $error("write changed run status");
   AST_EXEC_WAIT: assert property (q.trig[DTS_QUAL_BIT] & ~hits.exec |-> ~fire & ~bstore)
      else $error("tagged match triggered before execution");
   AST_CNT_MAX: assert property (q.cnt <= DTS_FIFO_DEPTH)
      else $error("valid count above fifo depth");
   AST_TRIG_OUT: assert property (q.phase != DTS_ST_IDLE & fire |=> trigger_event)
      else $error("trigger pulse missing after a match");

   // main scenarios worth seeing in a run
   COV_END_RUN: cover property (q.phase == DTS_ST_ARMED ##1 q.phase == DTS_ST_IDLE);
   COV_BEGIN_RUN: cover property (q.phase == DTS_ST_STORE ##1 q.phase == DTS_ST_IDLE);
   COV_TAGGED: cover property (q.trig[DTS_QUAL_BIT] & fire);
   COV_EVENT_STORE: cover property (q.phase == DTS_ST_ARMED & evonly & bstore);
endmodule

// ==== dts_hits_model.sv ====
// behavioural model of the comparator and opcode tracking side
`timescale 1ns/10ps
module dts_hits_model
(
   input  wire logic               pclk,    // cpu bus clock
   input  wire logic               presetn, // async reset, active low
   input  wire dts_pkg::dts_hits_t ev_req,  // event asked for by the bench
   output dts_pkg::dts_hits_t      hits     // events as the comparators present them
);
   import dts_pkg::*;
   // ****************************************************
   // event launch
   // ****************************************************
   // events come out of a flop, as a real comparator would register them
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         hits <= '0;
      else
         hits <= ev_req;
   end
endmodule

// ==== dts_debug_trigger_test.sv ====
// self-checking testbench of the debug trigger and run status block
`timescale 1ns/10ps
module dts_debug_trigger_test;
   import dts_pkg::*;
   // ****************************************************
   // signals
   // ****************************************************
   logic         pclk = 1'b0;    // 25 mhz bus clock
   logic         presetn = 1'b0; // reset held at start
   dts_apb_req_t req = '0;       // apb master request
   logic         pready;         // slave ready
   logic         pslverr;        // slave error
   logic [31:0]  prdata;         // read data
   dts_hits_t    ev_req = '0;    // event request to the model
   dts_hits_t    hits;           // events into the block
   logic         secure_mode = 1'b0; // mcu secured
   logic         fifo_store;     // store pulse
   logic         trigger_event;  // trigger pulse
   logic         run_armed;      // run in progress
   int           n_fail = 0;     // mismatches
   int           cmp_count = 0;  // comparisons
   int           n_trg = 0;      // trigger pulses seen
   int           n_st = 0;       // store pulses seen
   logic [31:0]  rv;             // last read value
   logic         re;             // last error response
   int           t0;             // trigger count snapshot
   int           s0;             // store count snapshot
   always #20 pclk = ~pclk;
   dts_debug_trigger DUT (.pclk(pclk), .presetn(presetn), .apb_req(req), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .hits(hits), .secure_mode(secure_mode),
      .fifo_store(fifo_store), .trigger_event(trigger_event), .run_armed(run_armed));
   dts_hits_model PARTNER (.pclk(pclk), .presetn(presetn), .ev_req(ev_req), .hits(hits));
   // pulses are one cycle wide, so a counter never misses one
   always @(posedge pclk)
   begin
      if (trigger_event === 1'b1) n_trg++;
      if (fifo_store === 1'b1) n_st++;
   end
   // ****************************************************
   // shared tasks
   // ****************************************************
   task test_done;
      begin
         if (n_fail == 0 && cmp_count > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         cmp_count++;
         if (got !== exp)
         begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // one apb transfer; the request stands until pready is seen high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      begin
         @(posedge pclk);
         req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
         @(posedge pclk);
         req.penable <= 1'b1;
         // no cycle limit of its own: only the watchdog ends a wait
         do
         begin
            @(posedge pclk);
         end
         while (pready !== 1'b1);
         rv = prdata;
         re = pslverr;
         req.psel <= 1'b0;
         req.penable <= 1'b0;
      end
   endtask
   task idle(input int n);
      begin
         repeat (n) @(posedge pclk);
         #1;
      end
   endtask
   // one cycle of events from the comparators
   task pulse(input logic [8:0] h);
      begin
         @(posedge pclk);
         ev_req <= h;
         @(posedge pclk);
         ev_req <= '0;
      end
   endtask
   // enable, load trigger setup, arm
   task arm(input logic [7:0] t);
      begin
         apb(1'b1, DTS_OFF_CTRL, 32'h0000_0080);
         apb(1'b1, DTS_OFF_TRIG, {24'h0, t});
         apb(1'b1, DTS_OFF_CTRL, 32'h0000_00c0);
         t0 = n_trg;
         s0 = n_st;
      end
   endtask
   // ****************************************************
   // scenarios
   // ****************************************************
   task s_regs;
      begin
         apb(1'b1, DTS_OFF_TRIG, 32'h0000_00ff);
         apb(1'b0, DTS_OFF_TRIG, 32'h0);
         chk(rv, 32'h0000_00cf);
         apb(1'b0, 8'h0c, 32'h0);
         chk({31'h0, re}, 32'h1);
         chk(rv, 32'h0);
         secure_mode <= 1'b1;
         apb(1'b1, DTS_OFF_CTRL, 32'h0000_0080);
         apb(1'b0, DTS_OFF_CTRL, 32'h0);
         chk(rv, 32'h0);
         secure_mode <= 1'b0;
      end
   endtask
   task s_end_trace;
      begin
         arm(8'h00);
         apb(1'b0, DTS_OFF_STATUS, 32'h0);
         chk(rv, 32'h0000_0020);
         chk({31'h0, run_armed}, 32'h1);
         apb(1'b1, DTS_OFF_TRIG, 32'h0000_0005);
         apb(1'b0, DTS_OFF_TRIG, 32'h0);
         chk(rv, 32'h0);
         repeat (3) pulse(9'h004);
         pulse(9'h180);
         idle(4);
         chk(32'(n_trg - t0), 32'h1);
         chk({31'h0, run_armed}, 32'h0);
         chk(32'(n_st - s0), 32'h3);
         apb(1'b0, DTS_OFF_STATUS, 32'h0);
         chk(rv, 32'h0000_0083);
         apb(1'b1, DTS_OFF_STATUS, 32'h0000_00ff);
         pulse(9'h140);
         apb(1'b0, DTS_OFF_STATUS, 32'h0);
         chk(rv, 32'h0000_0083);
         apb(1'b0, DTS_OFF_STATUS, 32'h0);
         chk(rv, 32'h0000_0083);
      end
   endtask
   task s_qualify;
      begin
         arm(8'h80);
         apb(1'b0, DTS_OFF_STATUS, 32'h0);
         chk(rv, 32'h0000_0020);
         pulse(9'h180);
         idle(4);
         chk(32'(n_trg - t0), 32'h0);
         pulse(9'h002);
         idle(4);
         chk(32'(n_trg - t0), 32'h1);
      end
   endtask
   task s_begin_trace;
      begin
         arm(8'h40);
         repeat (2) pulse(9'h004);
         apb(1'b0, DTS_OFF_STATUS, 32'h0);
         chk(rv, 32'h0000_0020);
         pulse(9'h180);
         repeat (9) pulse(9'h004);
         idle(3);
         chk({31'h0, run_armed}, 32'h0);
         chk(32'(n_st - s0), 32'h8);
         apb(1'b0, DTS_OFF_STATUS, 32'h0);
         chk(rv, 32'h0000_0088);
      end
   endtask
   // modes 0 to 8 get one or two event cycles that should make them fire, or store in modes 3 and 4; codes 9 to 15 get two that must not fire
   task s_modes;
      logic [8:0] ev1 [9];
      logic [8:0] ev2 [9];
      begin
         ev1 = '{9'h180, 9'h140, 9'h180, 9'h140, 9'h180, 9'h1a0, 9'h180, 9'h100, 9'h110};
         ev2 = '{9'h0, 9'h0, 9'h140, 9'h0, 9'h140, 9'h0, 9'h0, 9'h0, 9'h0};
         for (int m = 0; m < 9; m++)
         begin
            arm(8'(m));
            pulse(ev1[m]);
            if (ev2[m] != 9'h0) pulse(ev2[m]);
            idle(4);
            if (m == 3 || m == 4)
               chk(32'(n_st - s0 > 0), 32'h1);
            else
               chk(32'(n_trg - t0), 32'h1);
            apb(1'b1, DTS_OFF_CTRL, 32'h0000_0080);
            idle(1);
            chk({31'h0, run_armed}, 32'h0);
         end
         for (int m = 9; m < 16; m++)
         begin
            arm(8'(m));
            pulse(9'h180);
            pulse(9'h1d8);
            idle(4);
            chk(32'(n_trg - t0), 32'h0);
            apb(1'b1, DTS_OFF_CTRL, 32'h0);
            idle(1);
            chk({31'h0, run_armed}, 32'h0);
         end
      end
   endtask
   // ****************************************************
   // main sequence and watchdog
   // ****************************************************
   initial
   begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      s_regs();
      s_end_trace();
      s_qualify();
      s_begin_trace();
      s_modes();
      test_done();
   end
   // the whole sequence needs well under 2000 cycles
   initial
   begin
      #(40 * 20000);
      n_fail++;
      test_done();
   end
endmodule
